// [src/errq_pkg.sv]
// package for the command error queue: codes, sizes, record types
// assumes one 200 MHz clock domain and synchronous active-high reset
package errq_pkg;

	localparam int          DEPTH       = 20;
	localparam int          CODE_W      = 16;
	localparam int          MSG_MAX     = 80;
	localparam int          KEYWORD_MAX = 12;
	localparam int          SHORT_MAX   = 4;
	localparam int          EXP_MAX     = 32000;
	localparam int          MANT_MAX    = 255;
	localparam int          NUM_SRC     = 15;
	localparam longint      CLK_HZ      = 200000000;
	localparam longint      VIEW_TMO_S  = 30;
	localparam longint      VIEW_TMO_CYC = VIEW_TMO_S * CLK_HZ;

	localparam logic signed [CODE_W-1:0] C_NO_ERROR   = 16'sh0000;
	localparam logic signed [CODE_W-1:0] C_BAD_CHAR   = -16'sd101;
	localparam logic signed [CODE_W-1:0] C_SYNTAX     = -16'sd102;
	localparam logic signed [CODE_W-1:0] C_SEPARATOR  = -16'sd103;
	localparam logic signed [CODE_W-1:0] C_DATA_TYPE  = -16'sd104;
	localparam logic signed [CODE_W-1:0] C_TRIG_MID   = -16'sd105;
	localparam logic signed [CODE_W-1:0] C_EXTRA_PARM = -16'sd108;
	localparam logic signed [CODE_W-1:0] C_MISS_PARM  = -16'sd109;
	localparam logic signed [CODE_W-1:0] C_KW_LONG    = -16'sd112;
	localparam logic signed [CODE_W-1:0] C_UNDEF_HDR  = -16'sd113;
	localparam logic signed [CODE_W-1:0] C_HDR_SUFFIX = -16'sd114;
	localparam logic signed [CODE_W-1:0] C_NUM_OVFL   = -16'sd123;
	localparam logic signed [CODE_W-1:0] C_DIGITS     = -16'sd124;
	localparam logic signed [CODE_W-1:0] C_NUM_NOTOK  = -16'sd128;
	localparam logic signed [CODE_W-1:0] C_SUFFIX_BAD = -16'sd131;
	localparam logic signed [CODE_W-1:0] C_SUFFIX_LNG = -16'sd134;
	localparam logic signed [CODE_W-1:0] C_OVERFLOW   = -16'sd350;

	// fault report of one parsed command, one bit per detected fault
	typedef struct packed {
		logic bad_char;       // illegal character in keyword or parameter
		logic syntax;         // space beside header colon or before comma
		logic separator;      // wrong separator
		logic wrong_type;     // parameter of the wrong type
		logic num_for_string; // number where string expected
		logic trig_mid;       // trigger message inside a command string
		logic extra_parm;     // too many parameters
		logic missing_parm;   // too few parameters
		logic undef_hdr;      // unknown header
		logic hdr_suffix;     // header numeric suffix out of range
		logic suffix_long;    // parameter suffix too long
		logic suffix_bad;     // parameter suffix misspelled
	} fault_t;

	// measured properties of the command, checked against these limits in the queue
	typedef struct packed {
		logic [7:0]  keyword_len;  // longest header keyword, characters
		logic [15:0] exponent;     // numeric exponent magnitude
		logic [9:0]  mantissa_len; // mantissa digits without leading zeros
	} measure_t;

	// one reported entry: code plus index of its fixed message text
	typedef struct packed {
		logic signed [CODE_W-1:0] code;
		logic [4:0]               msg_idx;
	} entry_t;

endpackage : errq_pkg

// [src/command_error_queue.sv]
// command error queue: classifies parser faults, queues codes, reports
// assumes the parser presents one command report per valid pulse
// Function
// - oldest stored error delivered first
// - each remote read pops one entry
// - indicator off when queue empty
// - one beeper pulse per raised error (errors flushed by a clear get none)
// - overflow replaces newest entry with -350
// - discard errors after overflow until removal
// - empty read gives +0, panel shows none
// - status clear and power cycle empty queue
// - reset common command keeps queue
// - leaving panel view, or timeout, clears queue
// - entry is signed code, comma, quoted text (stored here as code plus message index)
// - illegal character raises -101
// - malformed syntax raises -102
// - wrong separator raises -103
// - wrong type -104, number for string -128
// - trigger inside command raises -105
// - extra parameters -108, missing -109
// - keyword over twelve characters raises -112
// - unknown header raises -113
// - header suffix out of range -114
// - exponent over 32000 -123, long mantissa -124
// - long suffix -134, misspelled suffix -131
`timescale 1ns/10ps
`default_nettype none

module command_error_queue #(
	parameter int     DEPTH    = errq_pkg::DEPTH,
	parameter longint VIEW_TMO = errq_pkg::VIEW_TMO_CYC
) (
	input  wire logic              clk_i,        // system clock
	input  wire logic              reset_i,      // power-on reset
	input  wire logic              cmd_valid_i,  // command report valid
	output logic                   cmd_ready_o,  // report taken
	input  wire errq_pkg::fault_t  fault_i,      // fault flags
	input  wire errq_pkg::measure_t measure_i,   // measured sizes
	input  wire logic              clear_cmd_i,  // status-clear command
	input  wire logic              reset_cmd_i,  // reset common command
	input  wire logic              read_i,       // remote error query
	output errq_pkg::entry_t       read_data_o,  // answered entry
	output logic                   read_valid_o, // answer strobe
	input  wire logic              view_exit_i,  // panel menu left by key
	input  wire logic              view_active_i,// panel viewing menu open
	input  wire logic [4:0]        view_sel_i,   // entry index to browse
	output errq_pkg::entry_t       view_data_o,  // browsed entry
	output logic                   view_none_o,  // panel shows no errors
	output logic                   error_led_o,  // error indicator
	output logic                   beep_o,       // beeper pulse
	output logic [5:0]             count_o       // entries stored
);

	localparam int PW = $clog2(DEPTH);
	localparam int NS = errq_pkg::NUM_SRC;

	errq_pkg::entry_t    mem [DEPTH];
	logic [PW-1:0]       rd_ptr;
	logic [PW-1:0]       wr_ptr;
	logic [5:0]          count;
	logic                overflowed;
	logic [NS-1:0]       pend;
	logic [NS-1:0]       raise;
	errq_pkg::entry_t    src_entry [NS];
	logic [63:0]         view_timer;
	logic                view_active_q;

	// fault to code table; order is detection order
	always_comb begin
		src_entry[0]  = '{errq_pkg::C_BAD_CHAR,   5'h01};
		src_entry[1]  = '{errq_pkg::C_SYNTAX,     5'h02};
		src_entry[2]  = '{errq_pkg::C_SEPARATOR,  5'h03};
		src_entry[3]  = '{errq_pkg::C_DATA_TYPE,  5'h04};
		src_entry[4]  = '{errq_pkg::C_NUM_NOTOK,  5'h05};
		src_entry[5]  = '{errq_pkg::C_TRIG_MID,   5'h06};
		src_entry[6]  = '{errq_pkg::C_EXTRA_PARM, 5'h07};
		src_entry[7]  = '{errq_pkg::C_MISS_PARM,  5'h08};
		src_entry[8]  = '{errq_pkg::C_KW_LONG,    5'h09};
		src_entry[9]  = '{errq_pkg::C_UNDEF_HDR,  5'h0A};
		src_entry[10] = '{errq_pkg::C_HDR_SUFFIX, 5'h0B};
		src_entry[11] = '{errq_pkg::C_NUM_OVFL,   5'h0C};
		src_entry[12] = '{errq_pkg::C_DIGITS,     5'h0D};
		src_entry[13] = '{errq_pkg::C_SUFFIX_LNG, 5'h0E};
		src_entry[14] = '{errq_pkg::C_SUFFIX_BAD, 5'h0F};
	end

	// size limits on the measured command fields
	logic kw_over;
	logic exp_over;
	logic mant_over;

	limit_flag #(
		.W(8)
	) limit_flag_kw_inst (
		.value_i (measure_i.keyword_len),
		.limit_i (8'(errq_pkg::KEYWORD_MAX)),
		.over_o  (kw_over)
	);

	limit_flag #(
		.W(16)
	) limit_flag_exp_inst (
		.value_i (measure_i.exponent),
		.limit_i (16'(errq_pkg::EXP_MAX)),
		.over_o  (exp_over)
	);

	limit_flag #(
		.W(10)
	) limit_flag_mant_inst (
		.value_i (measure_i.mantissa_len),
		.limit_i (10'(errq_pkg::MANT_MAX)),
		.over_o  (mant_over)
	);

	always_comb begin
		raise[0]  = fault_i.bad_char;
		raise[1]  = fault_i.syntax;
		raise[2]  = fault_i.separator;
		raise[3]  = fault_i.wrong_type & ~fault_i.num_for_string;
		raise[4]  = fault_i.num_for_string;
		raise[5]  = fault_i.trig_mid;
		raise[6]  = fault_i.extra_parm;
		raise[7]  = fault_i.missing_parm;
		raise[8]  = kw_over;
		raise[9]  = fault_i.undef_hdr;
		raise[10] = fault_i.hdr_suffix;
		raise[11] = exp_over;
		raise[12] = mant_over;
		raise[13] = fault_i.suffix_long;
		raise[14] = fault_i.suffix_bad;
	end

	// lowest pending source goes first, one per cycle
	logic          have_err;
	logic [3:0]    sel;
	always_comb begin
		have_err = 1'b0;
		sel      = 4'h0;
		for (int i = NS - 1; i >= 0; i--) begin
			if (pend[i]) begin
				have_err = 1'b1;
				sel      = 4'(i);
			end
		end
	end

	// new report accepted only after the previous one is drained
	assign cmd_ready_o = ~have_err;

	logic clear_all;
	logic view_tmo;
	logic pop;
	logic push;
	logic full;
	assign view_tmo  = view_active_i && view_timer >= 64'(VIEW_TMO - 1);
	assign clear_all = clear_cmd_i | view_exit_i | view_tmo;
	assign pop       = read_i && count != 6'h00;
	assign full      = count == 6'(DEPTH);
	assign push      = have_err && !full && !overflowed;

	// the first error that finds the queue full, with no pop that cycle, marks the newest entry
	logic over_hit;
	assign over_hit = have_err && full && !overflowed && !pop;

	always_ff @(posedge clk_i) begin
		if (reset_i || clear_all) begin
			pend <= '0;
		end else if (cmd_valid_i && cmd_ready_o) begin
			pend <= raise;
		end else if (have_err) begin
			pend[sel] <= 1'b0;
		end
	end

	logic [PW-1:0] next_rd_ptr;
	logic [PW-1:0] next_wr_ptr;
	always_comb begin
		next_rd_ptr = rd_ptr + 1'b1;
		if (rd_ptr == PW'(DEPTH - 1)) begin
			next_rd_ptr = '0;
		end
	end

	always_comb begin
		next_wr_ptr = wr_ptr + 1'b1;
		if (wr_ptr == PW'(DEPTH - 1)) begin
			next_wr_ptr = '0;
		end
	end

	// reset_cmd_i is deliberately not used to touch the queue
	always_ff @(posedge clk_i) begin
		if (reset_i || clear_all) begin
			rd_ptr <= '0;
		end else if (pop) begin
			rd_ptr <= next_rd_ptr;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i || clear_all) begin
			wr_ptr <= '0;
		end else if (push) begin
			wr_ptr <= next_wr_ptr;
		end
	end

	// overflow marker stays until an entry is removed
	always_ff @(posedge clk_i) begin
		if (reset_i || clear_all) begin
			overflowed <= 1'b0;
		end else if (over_hit) begin
			overflowed <= 1'b1;
		end else if (pop) begin
			overflowed <= 1'b0;
		end
	end

	logic [5:0] next_count;
	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + 6'h01;
		end else if (pop && !push) begin
			next_count = count - 6'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i || clear_all) begin
			count <= 6'h00;
		end else begin
			count <= next_count;
		end
	end

	logic [PW-1:0] newest;
	assign newest = (wr_ptr == '0) ? PW'(DEPTH - 1) : wr_ptr - 1'b1;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= src_entry[sel];
		end else if (over_hit) begin
			mem[newest] <= '{errq_pkg::C_OVERFLOW, 5'h10};
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			read_valid_o <= 1'b0;
		end else begin
			read_valid_o <= read_i;
		end
	end

	// an empty queue answers with the no-error entry
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			read_data_o <= '0;
		end else if (read_i) begin
			read_data_o <= (count != 6'h00) ? mem[rd_ptr]
				: errq_pkg::entry_t'{errq_pkg::C_NO_ERROR, 5'h00};
		end
	end

	// beeper fires for every raised error, even ones discarded, but not for errors still pending when clear_all flushes them
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			beep_o <= 1'b0;
		end else begin
			beep_o <= have_err && !clear_all;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			view_active_q <= 1'b0;
		end else begin
			view_active_q <= view_active_i;
		end
	end

	// timer restarts on each opening of the menu and after it fires
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			view_timer <= '0;
		end else if (!view_active_i || view_tmo || !view_active_q) begin
			view_timer <= '0;
		end else begin
			view_timer <= view_timer + 64'h1;
		end
	end

	logic [PW-1:0] view_ptr;
	always_comb begin
		view_ptr = PW'((32'(rd_ptr) + 32'(view_sel_i)) % DEPTH);
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			view_data_o <= '0;
		end else begin
			view_data_o <= mem[view_ptr];
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			view_none_o <= 1'b1;
		end else begin
			view_none_o <= count == 6'h00;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			error_led_o <= 1'b0;
		end else begin
			error_led_o <= count != 6'h00;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			count_o <= 6'h00;
		end else begin
			count_o <= count;
		end
	end

endmodule : command_error_queue

// flags a measured size above its allowed limit
module limit_flag #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] value_i, // measured size
	input  wire logic [W-1:0] limit_i, // largest legal size
	output logic              over_o   // size exceeds limit
);

	assign over_o = value_i > limit_i;

endmodule : limit_flag

`default_nettype wire

// [verification/host_model.sv]
// host model: turns each read request into one remote query pulse
// assumes single-cycle requests spaced a few cycles apart
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input  wire logic clk_i,  // system clock
	input  wire logic ask_i,  // read request
	input  wire logic slow_i, // one extra cycle of delay
	output logic      read_o  // remote query pulse
);
	logic held;
	always_ff @(posedge clk_i) begin
		held <= ask_i;
		read_o <= slow_i ? held : ask_i;
	end
endmodule : host_model
`default_nettype wire

// [verification/command_error_queue_asserts.sv]
// checker for the command error queue outputs
// bound into every command_error_queue instance
`timescale 1ns/10ps
`default_nettype none
module command_error_queue_asserts #(
	parameter int     DEPTH    = errq_pkg::DEPTH,
	parameter longint VIEW_TMO = errq_pkg::VIEW_TMO_CYC
) (
	input wire logic             clk_i,        // clock
	input wire logic             reset_i,      // reset
	input wire logic             cmd_valid_i,  // report offered
	input wire logic             cmd_ready_o,  // report taken
	input wire logic             clear_cmd_i,  // status clear
	input wire logic             read_i,       // remote read
	input wire errq_pkg::entry_t read_data_o,  // answer
	input wire logic             read_valid_o, // answer strobe
	input wire logic             view_exit_i,  // panel exit
	input wire logic             view_none_o,  // no errors shown
	input wire logic             error_led_o,  // indicator
	input wire logic             beep_o,       // beeper
	input wire logic [5:0]       count_o       // entries
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	property p_read; read_i |=> read_valid_o; endproperty
	a_read: assert property (p_read) else $error("read not answered");
	property p_led; error_led_o == (count_o != 6'h00); endproperty
	a_led: assert property (p_led) else $error("indicator wrong");
	property p_none; view_none_o == (count_o == 6'h00); endproperty
	a_none: assert property (p_none) else $error("panel state wrong");
	property p_empty;
		read_i && count_o == 6'h00 && cmd_ready_o && !cmd_valid_i
			&& $past(cmd_ready_o)
			|=> read_data_o.code == 16'h0000;
	endproperty
	a_empty: assert property (p_empty) else $error("empty read not zero");
	property p_cap; count_o <= DEPTH; endproperty
	a_cap: assert property (p_cap) else $error("count over capacity");
	property p_beep; count_o > $past(count_o) |-> $past(beep_o); endproperty
	a_beep: assert property (p_beep) else $error("no beep on error");
	property p_clear; clear_cmd_i |=> ##[0:1] count_o == 6'h00; endproperty
	a_clear: assert property (p_clear) else $error("clear ignored");
	property p_exit; view_exit_i |=> ##[0:1] count_o == 6'h00; endproperty
	a_exit: assert property (p_exit) else $error("exit left queue");
	property p_src; beep_o |-> !$past(cmd_ready_o); endproperty
	a_src: assert property (p_src) else $error("beep without report");
	c_full: cover property (count_o == DEPTH);
	c_eread: cover property (read_i && count_o == 6'h00);
	c_beep: cover property (beep_o);
endmodule : command_error_queue_asserts
bind command_error_queue command_error_queue_asserts #(
	.DEPTH(DEPTH), .VIEW_TMO(VIEW_TMO)
) command_error_queue_asserts_inst (.clk_i, .reset_i, .cmd_valid_i,
	.cmd_ready_o, .clear_cmd_i, .read_i, .read_data_o, .read_valid_o,
	.view_exit_i, .view_none_o, .error_led_o, .beep_o, .count_o);
`default_nettype wire

// [verification/command_error_queue_tb_top.sv]
// testbench for the command error queue
// drives parser reports; the host model issues remote reads
`timescale 1ns/10ps
`default_nettype none
module command_error_queue_tb_top;
	localparam int TMO = 50;
	typedef logic signed [15:0] code_t;
	localparam errq_pkg::measure_t OK_M = '{8'h0C, 16'h7D00, 10'h0FF};
	logic clk_i = 1'b0, reset_i = 1'b1, cmd_valid_i = 1'b0, cmd_ready_o;
	logic clear_cmd_i = 1'b0, reset_cmd_i = 1'b0, ask = 1'b0, slow = 1'b0;
	logic view_exit_i = 1'b0, view_active_i = 1'b0, read_i, read_valid_o;
	logic view_none_o, error_led_o, beep_o;
	logic [5:0] count_o;
	errq_pkg::fault_t fault_i = '0;
	errq_pkg::measure_t measure_i = '0;
	errq_pkg::entry_t read_data_o, view_data_o;
	int error_cnt = 0, tests_run = 0, beeps = 0;
	integer seed = 32'h9FC5;
	code_t exp_q[$];
	code_t codes[15] = '{errq_pkg::C_BAD_CHAR, errq_pkg::C_SYNTAX,
		errq_pkg::C_SEPARATOR, errq_pkg::C_DATA_TYPE, errq_pkg::C_NUM_NOTOK,
		errq_pkg::C_TRIG_MID, errq_pkg::C_EXTRA_PARM, errq_pkg::C_MISS_PARM,
		errq_pkg::C_KW_LONG, errq_pkg::C_UNDEF_HDR, errq_pkg::C_HDR_SUFFIX,
		errq_pkg::C_NUM_OVFL, errq_pkg::C_DIGITS, errq_pkg::C_SUFFIX_LNG,
		errq_pkg::C_SUFFIX_BAD};
	logic [11:0] fm[15] = '{12'h800, 12'h400, 12'h200, 12'h100, 12'h080,
		12'h040, 12'h020, 12'h010, 12'h000, 12'h008, 12'h004, 12'h000,
		12'h000, 12'h002, 12'h001};
	command_error_queue #(.VIEW_TMO(TMO)) command_error_queue_inst (
		.clk_i, .reset_i, .cmd_valid_i, .cmd_ready_o, .fault_i, .measure_i,
		.clear_cmd_i, .reset_cmd_i, .read_i, .read_data_o, .read_valid_o,
		.view_exit_i, .view_active_i, .view_sel_i(5'h00), .view_data_o,
		.view_none_o, .error_led_o, .beep_o, .count_o);
	host_model host_model_inst (.clk_i, .ask_i(ask), .slow_i(slow),
		.read_o(read_i));
	always #2.5 clk_i = ~clk_i;
	always @(posedge clk_i) if (beep_o === 1'b1) beeps++;
	always @(posedge clk_i) if (read_valid_o === 1'b1)
		chk(read_data_o.code, exp_q.pop_front());
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic send(input logic [11:0] f, input errq_pkg::measure_t m);
		cmd_valid_i <= 1'b1;
		fault_i <= f;
		measure_i <= m;
		@(posedge clk_i);
		while (cmd_ready_o !== 1'b1) @(posedge clk_i);
		cmd_valid_i <= 1'b0;
		repeat (20) @(posedge clk_i);
	endtask : send
	task automatic rd;
		ask <= 1'b1;
		@(posedge clk_i);
		ask <= 1'b0;
		repeat (5) @(posedge clk_i);
	endtask : rd
	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run
	initial begin
		#50000;
		error_cnt++;
		complete_run;
	end
	initial begin
		errq_pkg::measure_t m;
		repeat (16) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		for (int i = 0; i < 15; i++) begin
			m = '{8'({$random(seed)} % 13), 16'({$random(seed)} % 32001),
				10'({$random(seed)} % 256)};
			m.keyword_len = (i == 8) ? 8'h0D : m.keyword_len;
			m.exponent = (i == 11) ? 16'h7D01 : m.exponent;
			m.mantissa_len = (i == 12) ? 10'h100 : m.mantissa_len;
			send(fm[i], m);
			exp_q.push_back(codes[i]);
		end
		chk(view_data_o.code, codes[0]);
		exp_q.push_back(16'h0000);
		repeat (16) rd;
		chk({error_led_o, view_none_o, count_o}, 8'h40);
		$display("single faults done");
		send(12'h000, OK_M);
		chk(count_o, 6'h00);
		beeps = 0;
		send(12'hFFF, '{8'h0D, 16'h7D01, 10'h100});
		repeat (8) send(12'h800, OK_M);
		chk(count_o, 6'h14);
		chk(beeps, 22);
		for (int i = 0; i < 15; i++) if (i != 3) exp_q.push_back(codes[i]);
		repeat (5) exp_q.push_back(errq_pkg::C_BAD_CHAR);
		exp_q.push_back(errq_pkg::C_OVERFLOW);
		exp_q.push_back(errq_pkg::C_BAD_CHAR);
		slow <= 1'b1;
		rd;
		send(12'h800, OK_M);
		chk(count_o, 6'h14);
		repeat (20) rd;
		$display("overflow done");
		send(12'h600, OK_M);
		reset_cmd_i <= 1'b1;
		@(posedge clk_i);
		reset_cmd_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk(count_o, 6'h02);
		clear_cmd_i <= 1'b1;
		@(posedge clk_i);
		clear_cmd_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk(count_o, 6'h00);
		send(12'h800, OK_M);
		view_exit_i <= 1'b1;
		@(posedge clk_i);
		view_exit_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk(count_o, 6'h00);
		send(12'h800, OK_M);
		view_active_i <= 1'b1;
		repeat (TMO + 5) @(posedge clk_i);
		view_active_i <= 1'b0;
		chk(count_o, 6'h00);
		send(12'h800, OK_M);
		chk(count_o, 6'h01);
		reset_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk({error_led_o, count_o}, 7'h00);
		chk(16'(exp_q.size()), 16'h0000);
		$display("clears done");
		complete_run;
	end
endmodule : command_error_queue_tb_top
`default_nettype wire
